// File: verilog/nvref_regs.sv
`timescale 1ns/100ps
`include "nvref_map.svh"
module nvref_regs #(
    parameter int unsigned TWC_CYCLES = `NVREF_TWC_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oen,
    input wire logic strap_bit_2,
    input wire logic strap_bit_1,
    input wire logic strap_bit_0,
    output logic [7:0] reference_scale_code,
    output logic [7:0] temperature_slope_code,
    output logic [1:0] gain_select,
    output logic [2:0] gain_factor,
    output logic nv_busy
);
    ////////////////////////////////////////////////////////////////////////
    // nonvolatile array; init models the stored content recalled at power-up
    logic [7:0] nv_mem [0:`NVREF_NUM_REGS-1] = '{default: 8'h00};
    logic [7:0] act_r [0:`NVREF_NUM_REGS-1];
    logic [2:0] nvwr_addr_r;
    logic [7:0] nvwr_data_r;

    function automatic logic [2:0] gain_decode(input logic [1:0] sel);
        case (sel)
            2'h0: gain_decode = 3'h1;
            2'h3: gain_decode = 3'h4;
            default: gain_decode = 3'h2;
        endcase
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a <= `NVREF_LAST_ADDR);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] scl_sync_r, sda_sync_r, st2_sync_r, st1_sync_r, st0_sync_r;
    logic scl_d_r, sda_d_r;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            st2_sync_r <= 2'h0;
            st1_sync_r <= 2'h0;
            st0_sync_r <= 2'h0;
            scl_d_r <= 1'h1;
            sda_d_r <= 1'h1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            st2_sync_r <= {st2_sync_r[0], strap_bit_2};
            st1_sync_r <= {st1_sync_r[0], strap_bit_1};
            st0_sync_r <= {st0_sync_r[0], strap_bit_0};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end
    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];
    assign scl_rise = scl_s && !scl_d_r;
    assign scl_fall = !scl_s && scl_d_r;
    assign start_det = scl_s && scl_d_r && !sda_s && sda_d_r;
    assign stop_det = scl_s && scl_d_r && sda_s && !sda_d_r;

    ////////////////////////////////////////////////////////////////////////
    // protocol engine
    nvref_pkg::nvref_state_t state_r, state_nxt, ret_r, ret_nxt;
    nvref_pkg::nvref_ack_t ackk_r, ackk_nxt;
    logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, wdat_r, wdat_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic rw_r, rw_nxt, wrdone_r, wrdone_nxt, drive_r, drive_nxt;
    logic nack_r, nack_nxt, nvgo, recall_r;
    logic [31:0] wc_r, wc_nxt;
    logic [6:0] own_id;
    assign own_id = {`NVREF_ID_PREFIX, st2_sync_r[1], st1_sync_r[1], st0_sync_r[1]};

    always_comb begin
        state_nxt = state_r;
        ret_nxt = ret_r;
        ackk_nxt = ackk_r;
        sh_nxt = sh_r;
        ptr_nxt = ptr_r;
        wdat_nxt = wdat_r;
        bit_nxt = bit_r;
        rw_nxt = rw_r;
        wrdone_nxt = wrdone_r;
        drive_nxt = drive_r;
        nack_nxt = nack_r;
        wc_nxt = wc_r;
        nvgo = 1'b0;
        if (state_r == nvref_pkg::NVREF_NVWR) begin
            drive_nxt = 1'b0;
            if (wc_r == 32'h0) begin
                state_nxt = nvref_pkg::NVREF_IDLE;
            end else begin
                wc_nxt = wc_r - 32'h1;
            end
        end else if (stop_det) begin
            drive_nxt = 1'b0;
            state_nxt = nvref_pkg::NVREF_IDLE;
            if (wrdone_r) begin
                nvgo = 1'b1;
                wc_nxt = TWC_CYCLES - 32'h1;
                state_nxt = nvref_pkg::NVREF_NVWR;
            end
            wrdone_nxt = 1'b0;
        end else if (start_det) begin
            drive_nxt = 1'b0;
            bit_nxt = 4'h0;
            wrdone_nxt = 1'b0;
            state_nxt = nvref_pkg::NVREF_ID;
        end else if (state_r != nvref_pkg::NVREF_IDLE) begin
            if (scl_rise && state_r != nvref_pkg::NVREF_ACK) begin
                sh_nxt = {sh_r[6:0], sda_s};
                bit_nxt = bit_r + 4'h1;
            end
            if (scl_rise && state_r == nvref_pkg::NVREF_ACK) begin
                nack_nxt = (ackk_r == nvref_pkg::NVREF_ACK_MASTER) && sda_s;
            end
            if (scl_fall) begin
                if (state_r == nvref_pkg::NVREF_ACK) begin
                    drive_nxt = 1'b0;
                    bit_nxt = 4'h0;
                    state_nxt = ret_r;
                    if (ret_r == nvref_pkg::NVREF_RDATA) begin
                        if (nack_r) begin
                            state_nxt = nvref_pkg::NVREF_IDLE;
                        end else begin
                            sh_nxt = act_r[ptr_r[2:0]];
                            if (!addr_ok(ptr_r)) begin
                                sh_nxt = 8'hff;
                            end
                            drive_nxt = !sh_nxt[7];
                        end
                    end
                end else if (bit_r == 4'h8) begin
                    state_nxt = nvref_pkg::NVREF_ACK;
                    ackk_nxt = nvref_pkg::NVREF_ACK_SLAVE;
                    drive_nxt = 1'b1;
                    case (state_r)
                        nvref_pkg::NVREF_ID: begin
                            rw_nxt = sh_r[0];
                            if (sh_r[7:1] != own_id) begin
                                drive_nxt = 1'b0;
                                state_nxt = nvref_pkg::NVREF_IDLE;
                            end else if (sh_r[0]) begin
                                ret_nxt = nvref_pkg::NVREF_RDATA;
                                nack_nxt = 1'b0;
                            end else begin
                                ret_nxt = nvref_pkg::NVREF_ADDR;
                            end
                        end
                        nvref_pkg::NVREF_ADDR: begin
                            ptr_nxt = sh_r;
                            ret_nxt = nvref_pkg::NVREF_WDATA;
                        end
                        nvref_pkg::NVREF_WDATA: begin
                            wdat_nxt = sh_r;
                            wrdone_nxt = addr_ok(ptr_r);
                            ret_nxt = nvref_pkg::NVREF_WDATA;
                        end
                        default: begin
                            drive_nxt = 1'b0;
                            ackk_nxt = nvref_pkg::NVREF_ACK_MASTER;
                            ptr_nxt = ptr_r + 8'h1;
                        end
                    endcase
                end else if (state_r == nvref_pkg::NVREF_RDATA) begin
                    drive_nxt = !sh_r[7];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_r <= nvref_pkg::NVREF_IDLE;
            ret_r <= nvref_pkg::NVREF_IDLE;
            ackk_r <= nvref_pkg::NVREF_ACK_NONE;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            wdat_r <= 8'h00;
            bit_r <= 4'h0;
            rw_r <= 1'b0;
            wrdone_r <= 1'b0;
            drive_r <= 1'b0;
            nack_r <= 1'b0;
            wc_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            ret_r <= ret_nxt;
            ackk_r <= ackk_nxt;
            sh_r <= sh_nxt;
            ptr_r <= ptr_nxt;
            wdat_r <= wdat_nxt;
            bit_r <= bit_nxt;
            rw_r <= rw_nxt;
            wrdone_r <= wrdone_nxt;
            drive_r <= drive_nxt;
            nack_r <= nack_nxt;
            wc_r <= wc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage: nonvolatile cells commit on stop, active copy recalled on the first clock after reset
    always_ff @(posedge mclk) begin
        if (nvgo) begin
            nv_mem[ptr_r[2:0]] <= wdat_r;
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            recall_r <= 1'b1;
            nvwr_addr_r <= 3'h0;
            nvwr_data_r <= 8'h00;
            for (int i = 0; i < `NVREF_NUM_REGS; i++) begin
                act_r[i] <= 8'h00;
            end
        end else begin
            recall_r <= 1'b0;
            if (recall_r) begin
                for (int i = 0; i < `NVREF_NUM_REGS; i++) begin
                    act_r[i] <= nv_mem[i];
                end
            end else if (nvgo) begin
                nvwr_addr_r <= ptr_r[2:0];
                nvwr_data_r <= wdat_r;
                act_r[ptr_r[2:0]] <= wdat_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; spare bits of address 2 and addresses 3, 4 drive nothing
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reference_scale_code <= 8'h00;
            temperature_slope_code <= 8'h00;
            gain_select <= 2'h0;
            gain_factor <= 3'h1;
            nv_busy <= 1'b0;
            sda_out <= 1'b0;
            sda_oen <= 1'b1;
        end else begin
            reference_scale_code <= act_r[`NVREF_ADDR_REF];
            temperature_slope_code <= act_r[`NVREF_ADDR_SLOPE];
            gain_select <= act_r[`NVREF_ADDR_GAIN][`NVREF_GAIN_MSB:`NVREF_GAIN_LSB];
            gain_factor <= gain_decode(act_r[`NVREF_ADDR_GAIN][1:0]);
            nv_busy <= (state_nxt == nvref_pkg::NVREF_NVWR);
            sda_out <= 1'b0;
            sda_oen <= !drive_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_gain_map;
        @(posedge mclk) disable iff (!resetn)
        (act_r[2][1:0] == 2'h3) |=> (gain_factor == 3'h4);
    endproperty
    a_gain_map: assert property (p_gain_map) else $error("gain 11 not x4");
    property p_gain_mid;
        @(posedge mclk) disable iff (!resetn)
        (act_r[2][1] ^ act_r[2][0]) |=> (gain_factor == 3'h2);
    endproperty
    a_gain_mid: assert property (p_gain_mid) else $error("gain 01/10 not x2");
    property p_nv_quiet;
        @(posedge mclk) disable iff (!resetn)
        (state_r == nvref_pkg::NVREF_NVWR) |=> sda_oen;
    endproperty
    a_nv_quiet: assert property (p_nv_quiet) else $error("sda driven during nv write");
    property p_stop_commit;
        @(posedge mclk) disable iff (!resetn)
        nvgo |=> (state_r == nvref_pkg::NVREF_NVWR) ##1 (act_r[nvwr_addr_r] == nvwr_data_r);
    endproperty
    a_stop_commit: assert property (p_stop_commit) else $error("write not committed");
    property p_range;
        @(posedge mclk) disable iff (!resetn)
        nvgo |-> (ptr_r <= `NVREF_LAST_ADDR);
    endproperty
    a_range: assert property (p_range) else $error("write above last register");
    property p_ref_out;
        @(posedge mclk) disable iff (!resetn)
        ##1 1'b1 |-> (reference_scale_code == $past(act_r[0]));
    endproperty
    a_ref_out: assert property (p_ref_out) else $error("reference code stale");
    property p_id_match;
        @(posedge mclk) disable iff (!resetn)
        (state_r == nvref_pkg::NVREF_ID && state_nxt == nvref_pkg::NVREF_ACK)
            |-> (sh_r[7:1] == own_id);
    endproperty
    a_id_match: assert property (p_id_match) else $error("acked foreign id");
    property p_ptr_step;
        @(posedge mclk) disable iff (!resetn)
        (state_r == nvref_pkg::NVREF_RDATA && scl_fall && bit_r == 4'h8)
            |=> (ptr_r == $past(ptr_r) + 8'h1);
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("read pointer not stepped");
    property p_rd_dir;
        @(posedge mclk) disable iff (!resetn)
        (state_r == nvref_pkg::NVREF_RDATA) |-> rw_r;
    endproperty
    a_rd_dir: assert property (p_rd_dir) else $error("data sent on a write frame");
endmodule

// File: verilog/nvref_map.svh
// Functional notes
// - five byte registers at addresses 0 to 4, all held in nonvolatile storage.
// - every register can be read and written by the serial bus master.
// - two 8-bit converter codes scale the reference and the temperature term.
// - address 0 holds reference code n (bit 7 msb) feeding the reference converter.
// - address 1 holds slope code m feeding the slope converter.
// - bits 1:0 of address 2 select gain: 00 x1, 01 and 10 x2, 11 x4.
// - upper six bits of address 2 are spare storage with no function.
// - addresses 3 and 4 are spare storage bytes with no function.
// - at power-up the stored settings are recalled into the active registers.
// - a stop ending a write of data to addresses 0 to 4 starts the nonvolatile write; the bus is ignored until done.
// - only an id byte of 0101 plus the three strap levels is answered; lsb is read.
// - the read pointer starts at the given address and steps per data byte.
`ifndef NVREF_MAP_SVH
`define NVREF_MAP_SVH
`define NVREF_NUM_REGS 5
`define NVREF_ADDR_REF 3'h0
`define NVREF_ADDR_SLOPE 3'h1
`define NVREF_ADDR_GAIN 3'h2
`define NVREF_ADDR_STORE_A 3'h3
`define NVREF_ADDR_STORE_B 3'h4
`define NVREF_LAST_ADDR 8'h04
`define NVREF_ID_PREFIX 4'h5
`define NVREF_GAIN_LSB 0
`define NVREF_GAIN_MSB 1
`define NVREF_CLK_MHZ 10
`define NVREF_TWC_MS 20
`define NVREF_TWC_CYC (`NVREF_TWC_MS * 1000 * `NVREF_CLK_MHZ)
`endif

// File: verilog/nvref_pkg.sv
package nvref_pkg;
    typedef enum logic [6:0] {
        NVREF_IDLE = 7'h01,
        NVREF_ID = 7'h02,
        NVREF_ADDR = 7'h04,
        NVREF_WDATA = 7'h08,
        NVREF_RDATA = 7'h10,
        NVREF_ACK = 7'h20,
        NVREF_NVWR = 7'h40
    } nvref_state_t;
    typedef enum logic [1:0] {
        NVREF_ACK_NONE = 2'h0,
        NVREF_ACK_SLAVE = 2'h1,
        NVREF_ACK_MASTER = 2'h2
    } nvref_ack_t;
endpackage

// File: sim/nvref_i2c_master.sv
`timescale 1ns/100ps
module nvref_i2c_master (
    input wire logic mclk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_m
);
    // scl rests high between frames; sda released means pulled up
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic start();
        tick(2);
        sda_m = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(3);
        sda_m = 1'b0;
        tick(3);
        scl = 1'b0;
    endtask
    // low 5 cycles, high 3: 800 ns per bit, data moves only while low
    task automatic bit_io(input logic b, output logic got);
        tick(2);
        sda_m = b;
        tick(3);
        scl = 1'b1;
        tick(2);
        got = sda_line;
        tick(1);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_m = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(3);
        sda_m = 1'b1;
        tick(3);
    endtask
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) bit_io(v[i], g);
        bit_io(1'b1, g);
        ack = ~g;
    endtask
    // nack on the last byte ends the read
    task automatic get_byte(input logic last, output logic [7:0] v);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, g);
            v[i] = g;
        end
        bit_io(last, g);
    endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam int TWC = 200;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] strap = 3'h5;
    logic scl, sda_m, sda_out, sda_oen, nv_busy, sda_line, k;
    logic [7:0] ref_c, slope_c, d;
    logic [1:0] gsel;
    logic [2:0] gfac;
    logic [7:0] mem [0:4];
    int num_errors = 0;
    int n_tests = 0;
    int seed = 54553;
    always #50 mclk = ~mclk;
    // wired-and of both open-drain drivers with the pull-up
    assign sda_line = sda_m & (sda_oen | sda_out);
    nvref_regs #(.TWC_CYCLES(TWC)) uut (.mclk(mclk), .resetn(resetn), .scl(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oen(sda_oen), .strap_bit_2(strap[2]),
        .strap_bit_1(strap[1]), .strap_bit_0(strap[0]), .reference_scale_code(ref_c),
        .temperature_slope_code(slope_c), .gain_select(gsel), .gain_factor(gfac),
        .nv_busy(nv_busy));
    nvref_i2c_master bus (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] gain_of(input logic [1:0] c);
        case (c)
            2'h0: return 3'h1;
            2'h3: return 3'h4;
            default: return 3'h2;
        endcase
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_outs();
        chk("reference", mem[0], ref_c);
        chk("slope", mem[1], slope_c);
        chk("gain_select", {6'h0, mem[2][1:0]}, {6'h0, gsel});
        chk("gain_factor", {5'h0, gain_of(mem[2][1:0])}, {5'h0, gfac});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic k0, k1, k2, ok;
        ok = (a <= 8'h04);
        bus.start();
        bus.put_byte({4'h5, strap, 1'b0}, k0);
        bus.put_byte(a, k1);
        bus.put_byte(v, k2);
        bus.stop();
        chk("write acks", 8'h07, {5'h0, k0, k1, k2});
        if (ok) mem[a[2:0]] = v;
        repeat (4) @(negedge mclk);
        chk("busy after stop", {7'h0, ok}, {7'h0, nv_busy});
        check_outs();
        // ignored during a write cycle; a discarded write starts none, so it is answered
        bus.start();
        bus.put_byte({4'h5, strap, 1'b0}, k0);
        bus.stop();
        chk("ack while busy", {7'h0, !ok}, {7'h0, k0});
        chk("busy held", {7'h0, ok}, {7'h0, nv_busy});
        repeat (TWC) @(negedge mclk);
        chk("busy cleared", 8'h00, {7'h0, nv_busy});
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        logic k0, k1, k2;
        logic [7:0] v, p;
        bus.start();
        bus.put_byte({4'h5, strap, 1'b0}, k0);
        bus.put_byte(a, k1);
        bus.start();
        bus.put_byte({4'h5, strap, 1'b1}, k2);
        chk("read acks", 8'h07, {5'h0, k0, k1, k2});
        for (int i = 0; i < n; i++) begin
            p = a + i[7:0];
            bus.get_byte(i == n - 1, v);
            chk("read data", (p <= 8'h04) ? mem[p[2:0]] : 8'hff, v);
        end
        bus.stop();
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
        repeat (6) @(negedge mclk);
        for (int i = 0; i < 5; i++) mem[i] = 8'h00;
        check_outs();
        $display("test power-up recall done");
        for (int i = 0; i < 5; i++) wr(i[7:0], 8'($random(seed)));
        rd(8'h00, 7);
        $display("test random writes and read done");
        strap = 3'h2;
        repeat (4) @(negedge mclk);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            wr(8'h02, {d[7:2], i[1:0]});
        end
        rd(8'h02, 1);
        // current-address read picks up where the last read left the pointer
        bus.start();
        bus.put_byte({4'h5, strap, 1'b1}, k);
        bus.get_byte(1'b1, d);
        bus.stop();
        chk("current read ack", 8'h01, {7'h0, k});
        chk("current read", mem[3], d);
        $display("test gain codes done");
        wr(8'h05, 8'h5a);
        wr(8'hff, 8'ha5);
        rd(8'h03, 3);
        for (int i = 0; i < 3; i++) begin
            bus.start();
            bus.put_byte({4'h5, strap ^ (3'h1 << i), 1'b0}, k);
            bus.stop();
            chk("foreign id ack", 8'h00, {7'h0, k});
        end
        $display("test refused accesses done");
        resetn = 1'b0;
        repeat (2) @(negedge mclk);
        chk("reference in reset", 8'h00, ref_c);
        chk("gain in reset", 8'h01, {5'h0, gfac});
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        check_outs();
        rd(8'h00, 5);
        $display("test power cycle done");
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        $display("Error watchdog expected end seen hang");
        give_verdict();
    end
endmodule
